//--- pkg/arf_pkg.sv
package arf_pkg;

	// ---------------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL_B = 8'h00;
	localparam logic [7:0] OFS_CONTROL_C = 8'h04;
	localparam logic [7:0] OFS_CONTROL_F = 8'h08;
	localparam logic [7:0] OFS_COMMAND = 8'h0c;
	localparam logic [7:0] OFS_POS_MUX = 8'h10;
	localparam logic [7:0] OFS_NEG_MUX = 8'h14;
	localparam logic [7:0] OFS_AMP_CTRL = 8'h18;
	localparam logic [7:0] OFS_CONV_IN = 8'h1c;
	localparam logic [7:0] OFS_SAMPLE = 8'h20;
	localparam logic [7:0] OFS_RESULT = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;

	// ---------------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------------
	localparam int CB_DIV_LSB = 0;
	localparam int CC_REF_LSB = 0;
	localparam int CC_TB_LSB = 8;
	localparam int CF_EXP_LSB = 0;
	localparam int CF_CONT_BIT = 5;
	localparam int CF_LEFT_BIT = 6;
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_DIFFERENTIAL_SELECT_BIT = 4;
	localparam int MUX_SEL_LSB = 0;
	localparam int MUX_VIA_LSB = 6;
	localparam int AMP_EN_BIT = 0;
	localparam int AMP_GAIN_LSB = 4;
	localparam int AMP_BIAS_LSB = 8;

	// ---------------------------------------------------------------------
	// Reset values and constants
	// ---------------------------------------------------------------------
	localparam logic [3:0] DIV_RESET = 4'h0;
	localparam logic [4:0] TB_RESET = 5'h01;
	localparam logic [3:0] SCALE_EXP = 4'h4;
	localparam logic [2:0] MODE_MAX = 3'h5;
	localparam logic [2:0] GAIN_MAX = 3'h4;
	localparam int TB_WIDTH = 5;
	localparam int DIV_WIDTH = 4;

	// Operation modes.
	typedef enum logic [2:0] {
		MODE_SINGLE8 = 3'h0,
		MODE_SINGLE12 = 3'h1,
		MODE_SERIES = 3'h2,
		MODE_SERIES_SCALED = 3'h3,
		MODE_BURST = 3'h4,
		MODE_BURST_SCALED = 3'h5
	} arf_mode_type;

	// Formatting configuration carried together.
	typedef struct packed {
		arf_mode_type mode;
		logic differentialSelect;
		logic leftAlign;
		logic [3:0] accumulateCountExponent;
	} arf_format_type;

	// Analog routing outputs carried together.
	typedef struct packed {
		logic [5:0] positiveInputSelect;
		logic [5:0] negativeInputSelect;
		logic [2:0] referenceSelect;
		logic amplifierEnable;
		logic [2:0] amplifierGain;
		logic [1:0] amplifierVia;
		logic [1:0] amplifierBiasSelect;
	} arf_route_type;

endpackage

//--- src/arf_control.sv
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Differential results are two's complement, sign copied into all upper bits.
// - Twelve-bit left align shifts the conversion left four, sign-extending above.
// - Left align is ignored in 8-bit mode and by the result word of unscaled accumulation modes.
// - Scaled left align with exponent below four shifts left by four minus exponent.
// - Sample word holds 8-bit or 12-bit conversion, zero or sign filled.
// - Converter clock is the peripheral clock divided per the divider field.
// - A microsecond tick counts programmed peripheral clock cycles.
// - Negative selection is routed only for differential conversions.
// - Reference follows the reference selection field.
// - Input and reference writes take effect at once, unbuffered.
// - Gains 1x to 16x supported, amplifier usable in every mode.
// - Amplifier is disabled after reset.
// - Writing one to amplifier enable turns it on with programmed gain.
// - One shared amplifier routing field seen in both multiplexer registers.
// - Amplifier bias selection field is provided for power reduction.
// - Six operation modes encoded zero to five.
// - Sample word updates on every conversion.
// - Scaled modes right shift the accumulation by exponent minus four.
module arf_control
	import arf_pkg::*;
#(
	parameter int DIVIDER_BITS = DIV_WIDTH,
	parameter int TIMEBASE_BITS = TB_WIDTH
)(
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter core interface.
	input wire logic conversionDone,
	input wire logic accumulationDone,
	input wire logic [11:0] conversionData,
	input wire logic [23:0] accumulationData,
	output logic converterClock,
	output logic microsecondTick,
	output arf_route_type route,
	output arf_format_type format,
	output logic continuousConversion
);

	// ---------------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------------
	initial begin
		if (DIVIDER_BITS < 1 || DIVIDER_BITS > 4) begin
			$error("DIVIDER_BITS must be 1 to 4.");
		end
		if (TIMEBASE_BITS < 1 || TIMEBASE_BITS > 8) begin
			$error("TIMEBASE_BITS must be 1 to 8.");
		end
		if (CC_TB_LSB + TIMEBASE_BITS > 16) begin
			$error("Timebase field must end below bit 16.");
		end
	end

	// ---------------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------------
	logic [DIVIDER_BITS-1:0] clockDividerSelect;
	logic [TIMEBASE_BITS-1:0] timebase;
	logic [2:0] referenceSelect;
	logic [3:0] accumulateCountExponent;
	logic leftAlign;
	logic differentialSelect;
	logic [2:0] mode;
	logic [5:0] positiveInputSelect;
	logic [5:0] negativeInputSelect;
	logic [1:0] amplifierVia;
	logic amplifierEnable;
	logic [2:0] amplifierGain;
	logic [1:0] amplifierBiasSelect;
	logic [15:0] latestSample;
	logic [31:0] conversionResult;
	logic [15:0] sampleWord;
	logic [31:0] resultWord;

	// ---------------------------------------------------------------------
	// AHB-Lite address phase capture
	// ---------------------------------------------------------------------
	logic dataWrite;
	logic dataRead;
	logic [7:0] dataAddr;
	logic takeTransfer;

	assign takeTransfer = hsel & hready & htrans[1];

	// Latch address phase so the data phase knows what to do.
	always_ff @(posedge clk) begin
		if (rst) begin
			dataWrite <= 1'b0;
			dataRead <= 1'b0;
			dataAddr <= 8'h00;
		end else if (hready) begin
			dataWrite <= takeTransfer & hwrite;
			dataRead <= takeTransfer & ~hwrite;
			dataAddr <= haddr;
		end
	end

	// A read whose address phase meets a write's data phase would capture the
	// register before that write lands. One wait state lets the write land first.
	logic readAfterWrite;
	logic stallDone;
	logic timebaseWrite;
	logic dividerWrite;

	assign readAfterWrite = dataWrite & hsel & htrans[1] & ~hwrite;

	// Marks that the single wait state has been served, so the stall cannot last.
	always_ff @(posedge clk) begin
		if (rst) begin
			stallDone <= 1'b0;
		end else begin
			stallDone <= ~hreadyout;
		end
	end

	// Wait state only for a read after a write; the response is always OKAY.
	assign hreadyout = ~(readAfterWrite & ~stallDone);
	assign hresp = 1'b0;

	// Writes that restart the timing counters, so no short period follows a change.
	assign timebaseWrite = dataWrite & (dataAddr == OFS_CONTROL_C);
	assign dividerWrite = dataWrite & (dataAddr == OFS_CONTROL_B);

	// Writes land on the data phase; selections apply with no shadow copy.
	always_ff @(posedge clk) begin
		if (rst) begin
			clockDividerSelect <= DIV_RESET[DIVIDER_BITS-1:0];
			timebase <= TIMEBASE_BITS'(TB_RESET);
			referenceSelect <= 3'h0;
			accumulateCountExponent <= 4'h0;
			leftAlign <= 1'b0;
			continuousConversion <= 1'b0;
			differentialSelect <= 1'b0;
			mode <= MODE_SINGLE8;
			positiveInputSelect <= 6'h00;
			negativeInputSelect <= 6'h00;
			amplifierVia <= 2'h0;
			amplifierEnable <= 1'b0;
			amplifierGain <= 3'h0;
			amplifierBiasSelect <= 2'h0;
		end else if (dataWrite) begin
			case (dataAddr)
				OFS_CONTROL_B: begin
					clockDividerSelect <= hwdata[CB_DIV_LSB +: DIVIDER_BITS];
				end
				OFS_CONTROL_C: begin
					referenceSelect <= hwdata[CC_REF_LSB +: 3];
					timebase <= hwdata[CC_TB_LSB +: TIMEBASE_BITS];
				end
				OFS_CONTROL_F: begin
					accumulateCountExponent <= hwdata[CF_EXP_LSB +: 4];
					continuousConversion <= hwdata[CF_CONT_BIT];
					leftAlign <= hwdata[CF_LEFT_BIT];
				end
				OFS_COMMAND: begin
					if (hwdata[CMD_MODE_LSB +: 3] <= MODE_MAX) begin
						mode <= hwdata[CMD_MODE_LSB +: 3];
					end
					differentialSelect <= hwdata[CMD_DIFFERENTIAL_SELECT_BIT];
				end
				OFS_POS_MUX: begin
					positiveInputSelect <= hwdata[MUX_SEL_LSB +: 6];
					amplifierVia <= hwdata[MUX_VIA_LSB +: 2];
				end
				OFS_NEG_MUX: begin
					negativeInputSelect <= hwdata[MUX_SEL_LSB +: 6];
					amplifierVia <= hwdata[MUX_VIA_LSB +: 2];
				end
				OFS_AMP_CTRL: begin
					amplifierEnable <= hwdata[AMP_EN_BIT];
					if (hwdata[AMP_GAIN_LSB +: 3] <= GAIN_MAX) begin
						amplifierGain <= hwdata[AMP_GAIN_LSB +: 3];
					end
					amplifierBiasSelect <= hwdata[AMP_BIAS_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (takeTransfer & ~hwrite) begin
			case (haddr)
				OFS_CONTROL_B: hrdata <= 32'(clockDividerSelect);
				OFS_CONTROL_C: hrdata <= 32'(referenceSelect) | (32'(timebase) << CC_TB_LSB);
				OFS_CONTROL_F: hrdata <= 32'(accumulateCountExponent)
					| (32'(continuousConversion) << CF_CONT_BIT)
					| (32'(leftAlign) << CF_LEFT_BIT);
				OFS_COMMAND: hrdata <= 32'(mode) | (32'(differentialSelect) << CMD_DIFFERENTIAL_SELECT_BIT);
				OFS_POS_MUX: hrdata <= 32'(positiveInputSelect)
					| (32'(amplifierVia) << MUX_VIA_LSB);
				OFS_NEG_MUX: hrdata <= 32'(negativeInputSelect)
					| (32'(amplifierVia) << MUX_VIA_LSB);
				OFS_AMP_CTRL: hrdata <= 32'(amplifierEnable)
					| (32'(amplifierGain) << AMP_GAIN_LSB)
					| (32'(amplifierBiasSelect) << AMP_BIAS_LSB);
				OFS_SAMPLE: hrdata <= 32'(latestSample);
				OFS_RESULT: hrdata <= conversionResult;
				OFS_STATUS: hrdata <= 32'(converterClock);
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------------
	// Output formatting
	// ---------------------------------------------------------------------
	// The formatter sees the live configuration registers.
	assign format.mode = arf_mode_type'(mode);
	assign format.differentialSelect = differentialSelect;
	assign format.leftAlign = leftAlign;
	assign format.accumulateCountExponent = accumulateCountExponent;

	arf_formatter formatter (
		.cfg(format),
		.conversion(conversionData),
		.accumulation(accumulationData),
		.sampleWord(sampleWord),
		.resultWord(resultWord)
	);

	// Sample updates every conversion; result on single conversions or accumulation end.
	always_ff @(posedge clk) begin
		if (rst) begin
			latestSample <= 16'h0000;
			conversionResult <= 32'h0000_0000;
		end else begin
			if (conversionDone) begin
				latestSample <= sampleWord;
			end
			if (conversionDone && (mode <= MODE_SINGLE12)) begin
				conversionResult <= resultWord;
			end else if (accumulationDone && (mode > MODE_SINGLE12)) begin
				conversionResult <= resultWord;
			end
		end
	end

	// ---------------------------------------------------------------------
	// Converter clock divider
	// ---------------------------------------------------------------------
	logic [15:0] divCount;

	// Counter restarts on a divider write; bit N gives division by 2^(N+1).
	always_ff @(posedge clk) begin
		if (rst) begin
			divCount <= 16'h0000;
		end else if (dividerWrite) begin
			divCount <= 16'h0000;
		end else begin
			divCount <= divCount + 16'h0001;
		end
	end

	// Registered tap keeps the clock output glitch free.
	// A divider write parks it low while the counter restarts.
	always_ff @(posedge clk) begin
		if (rst) begin
			converterClock <= 1'b0;
		end else if (dividerWrite) begin
			converterClock <= 1'b0;
		end else begin
			converterClock <= divCount[clockDividerSelect];
		end
	end

	// ---------------------------------------------------------------------
	// Microsecond timebase
	// ---------------------------------------------------------------------
	logic [TIMEBASE_BITS-1:0] tbCount;

	// Counts timebase cycles, pulsing once per microsecond.
	// A timebase of zero or one gives a tick on every cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			tbCount <= '0;
			microsecondTick <= 1'b0;
		end else if (timebaseWrite) begin
			tbCount <= '0;
			microsecondTick <= 1'b0;
		end else if (tbCount + 1'b1 >= timebase) begin
			tbCount <= '0;
			microsecondTick <= 1'b1;
		end else begin
			tbCount <= tbCount + 1'b1;
			microsecondTick <= 1'b0;
		end
	end

	// ---------------------------------------------------------------------
	// Analog routing
	// ---------------------------------------------------------------------
	// Selections go straight out; negative select reads zero when single-ended.
	assign route.positiveInputSelect = positiveInputSelect;
	assign route.negativeInputSelect = differentialSelect ? negativeInputSelect : 6'h00;
	assign route.referenceSelect = referenceSelect;
	assign route.amplifierEnable = amplifierEnable;
	assign route.amplifierGain = amplifierGain;
	assign route.amplifierVia = amplifierVia;
	assign route.amplifierBiasSelect = amplifierBiasSelect;

endmodule // arf_control

//--- src/arf_formatter.sv
`timescale 1ns/10ps
module arf_formatter
	import arf_pkg::*;
(
	input wire arf_format_type cfg,
	input wire logic [11:0] conversion,
	input wire logic [23:0] accumulation,
	output logic [15:0] sampleWord,
	output logic [31:0] resultWord
);

	// ---------------------------------------------------------------------
	// Combinational output formatting
	// ---------------------------------------------------------------------
	logic [31:0] convExt;
	logic [31:0] accExt;
	logic [31:0] scaled;
	logic sign8;
	logic sign12;
	logic signAcc;
	logic isScaled;

	// Sign bits are only meaningful for differential conversions.
	assign sign8 = cfg.differentialSelect & conversion[7];
	assign sign12 = cfg.differentialSelect & conversion[11];
	assign signAcc = cfg.differentialSelect & accumulation[23];
	assign isScaled = (cfg.mode == MODE_SERIES_SCALED) || (cfg.mode == MODE_BURST_SCALED);

	// Sample word and single-mode results, sign-extended when differential.
	always_comb begin
		if (cfg.mode == MODE_SINGLE8) begin
			convExt = {{24{sign8}}, conversion[7:0]};
		end else if (cfg.leftAlign) begin
			convExt = {{16{sign12}}, conversion, 4'h0};
		end else begin
			convExt = {{20{sign12}}, conversion};
		end
	end

	// Accumulated value, right aligned and sign-extended.
	assign accExt = {{8{signAcc}}, accumulation};

	// Scaling: right shift by exponent minus four, or with left align a left shift when below four.
	always_comb begin
		if (cfg.accumulateCountExponent >= SCALE_EXP) begin
			scaled = $signed(accExt) >>> (cfg.accumulateCountExponent - SCALE_EXP);
		end else if (cfg.leftAlign) begin
			scaled = accExt << (SCALE_EXP - cfg.accumulateCountExponent);
		end else begin
			scaled = accExt;
		end
		scaled = {{16{cfg.differentialSelect & scaled[15]}}, scaled[15:0]};
	end

	assign sampleWord = convExt[15:0];

	// Result word per mode.
	always_comb begin
		case (cfg.mode)
			MODE_SINGLE8, MODE_SINGLE12: resultWord = convExt;
			MODE_SERIES, MODE_BURST: resultWord = accExt;
			default: resultWord = isScaled ? scaled : convExt;
		endcase
	end

endmodule // arf_formatter

//--- testbench/arf_control_checker.sv
`timescale 1ns/10ps
module arf_control_checker
	import arf_pkg::*;
#(
	parameter int DIVIDER_BITS = DIV_WIDTH,
	parameter int TIMEBASE_BITS = TB_WIDTH
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic converterClock,
	input wire logic microsecondTick,
	input wire arf_route_type route,
	input wire arf_format_type format
);
	// ---------------------------------------------------------------
	// Write tracking
	// ---------------------------------------------------------------
	logic wOn, clkPrev, tickSeen;
	logic [1:0] clkSeen;
	logic [7:0] wAddr;
	logic [TIMEBASE_BITS-1:0] tbVal;
	logic [3:0] divVal;
	logic [15:0] tickGap, clkRun;
	wire logic wrPos = wOn && wAddr == OFS_POS_MUX;
	wire logic wrNeg = wOn && wAddr == OFS_NEG_MUX;
	wire logic wrC = wOn && wAddr == OFS_CONTROL_C;
	wire logic wrB = wOn && wAddr == OFS_CONTROL_B;
	wire logic wrAmp = wOn && wAddr == OFS_AMP_CTRL;
	wire logic wrCmd = wOn && wAddr == OFS_COMMAND;
	wire logic clkToggle = converterClock != clkPrev;

	// Marks the data phase of a write and shadows the timing fields.
	always_ff @(posedge clk) begin
		wOn <= hsel && hready && htrans[1] && hwrite && !rst;
		wAddr <= haddr;
		tbVal <= rst ? TIMEBASE_BITS'(TB_RESET) :
			(wrC ? hwdata[CC_TB_LSB +: TIMEBASE_BITS] : tbVal);
		divVal <= rst ? DIV_RESET : (wrB ? hwdata[3:0] : divVal);
	end

	// Counts cycles between ticks and between divided clock edges.
	always_ff @(posedge clk) begin
		clkPrev <= converterClock;
		tickGap <= (rst || wrC || microsecondTick) ? 16'h0000 : tickGap + 16'h0001;
		tickSeen <= (rst || wrC) ? 1'b0 : (microsecondTick ? 1'b1 : tickSeen);
		clkRun <= (rst || wrB || clkToggle) ? 16'h0000 : clkRun + 16'h0001;
		// The first two edges after a divider write may come early or late, so both are skipped.
		clkSeen <= (rst || wrB) ? 2'h0 :
			((clkToggle && !clkSeen[1]) ? clkSeen + 2'h1 : clkSeen);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	a_neg_single_end: assert property (
		!format.differentialSelect |-> route.negativeInputSelect == 6'h00)
		else $error("negative select routed in single-ended use");
	a_pos_write_now: assert property (
		wrPos |=> route.positiveInputSelect == $past(hwdata[5:0]))
		else $error("positive select not applied at once");
	a_ref_write_now: assert property (
		wrC |=> route.referenceSelect == $past(hwdata[2:0]))
		else $error("reference select not applied at once");
	a_via_shared: assert property (
		(wrPos || wrNeg) |=> route.amplifierVia == $past(hwdata[7:6]))
		else $error("shared amplifier routing not updated");
	a_amp_reset_off: assert property (
		$fell(rst) |-> !route.amplifierEnable)
		else $error("amplifier enabled after reset");
	a_amp_gain_set: assert property (
		wrAmp && hwdata[6:4] <= GAIN_MAX |=> route.amplifierEnable == $past(hwdata[0])
		&& route.amplifierGain == $past(hwdata[6:4]))
		else $error("amplifier enable or gain not taken");
	a_gain_refused: assert property (
		wrAmp && hwdata[6:4] > GAIN_MAX |=> $stable(route.amplifierGain))
		else $error("out of range gain accepted");
	a_bias_write: assert property (
		wrAmp |=> route.amplifierBiasSelect == $past(hwdata[9:8]))
		else $error("bias selection not taken");
	a_mode_range: assert property (
		wrCmd |=> format.mode == (($past(hwdata[2:0]) <= MODE_MAX) ?
		$past(hwdata[2:0]) : $past(format.mode)))
		else $error("operation mode write mishandled");
	a_tick_spacing: assert property (
		microsecondTick && tickSeen |-> tickGap == ((tbVal < 2) ? 16'h0000 :
		16'(tbVal) - 16'h0001))
		else $error("timebase tick spacing wrong");
	a_div_period: assert property (
		clkToggle && clkSeen[1] |-> clkRun == (16'h0001 << divVal) - 16'h0001)
		else $error("converter clock half period wrong");

	c_amp_write: cover property (wrAmp && hwdata[0]);
	c_tick_seen: cover property (microsecondTick && tickSeen);
	c_differential_select_route: cover property (format.differentialSelect && route.negativeInputSelect != 6'h00);
endmodule // arf_control_checker

bind arf_control arf_control_checker #(.DIVIDER_BITS(DIVIDER_BITS),
	.TIMEBASE_BITS(TIMEBASE_BITS)) u_chk (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.converterClock(converterClock), .microsecondTick(microsecondTick), .route(route),
	.format(format));

//--- testbench/arf_control_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errTotal++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module arf_control_tb
	import arf_pkg::*;
;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, conversionDone, accumulationDone;
	logic converterClock, microsecondTick, continuousConversion;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata;
	logic [11:0] conversionData;
	logic [23:0] accumulationData;
	arf_route_type route;
	arf_format_type format;
	wire logic hready = hreadyout;
	int errTotal = 0;
	int samplesChecked = 0;

	// Seven timebase bits hold the 100 cycles of one microsecond at 100 MHz.
	arf_control #(.TIMEBASE_BITS(7))
	dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .conversionDone(conversionDone),
		.accumulationDone(accumulationDone), .conversionData(conversionData),
		.accumulationData(accumulationData), .converterClock(converterClock),
		.microsecondTick(microsecondTick), .route(route), .format(format),
		.continuousConversion(continuousConversion));

	// ---------------------------------------------------------------
	// Bus and converter drivers
	// ---------------------------------------------------------------
	// One single-word transfer: address phase, then data phase.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'b0, a, 32'h0, r);
	endtask

	// A one-cycle completion pulse; data is scrambled once it is no longer valid.
	task automatic pulse(input logic acc, input logic [11:0] c, input logic [23:0] a);
		@(posedge clk);
		conversionDone <= !acc;
		accumulationDone <= acc;
		conversionData <= c;
		accumulationData <= a;
		@(posedge clk);
		conversionDone <= 1'b0;
		accumulationDone <= 1'b0;
		conversionData <= ~c;
		accumulationData <= ~a;
	endtask

	// Expected sample word (upper 16 bits) and result word (lower 32 bits).
	function automatic logic [47:0] fmt(input logic [2:0] m, input logic df, lf,
		input logic [3:0] e, input logic [11:0] c, input logic [23:0] a);
		logic [15:0] s;
		logic signed [31:0] r, sa;
		s = (m == 3'h0) ? {{8{df & c[7]}}, c[7:0]} : (lf ? {c, 4'h0} : {{4{df & c[11]}}, c});
		sa = df ? {{8{a[23]}}, a} : {8'h00, a};
		if (m < 3'h2) begin
			r = {{16{df & s[15]}}, s};
		end else if (m == 3'h2 || m == 3'h4) begin
			r = sa;
		end else begin
			r = (e >= 4'h4) ? sa >>> (e - 4'h4) : sa;
			if (lf && e < 4'h4) r = r << (4'h4 - e);
			r = {{16{df & r[15]}}, r[15:0]};
		end
		return {s, r};
	endfunction

	task automatic fmt_case(input logic [2:0] m, input logic df, lf, input logic [3:0] e,
		input logic [11:0] c, input logic [23:0] a);
		logic [47:0] x;
		logic [31:0] r;
		x = fmt(m, df, lf, e, c, a);
		wr(OFS_CONTROL_F, {25'h0, lf, 2'h0, e});
		wr(OFS_COMMAND, {27'h0, df, 1'b0, m});
		pulse(1'b0, c, a);
		if (m > 3'h1) pulse(1'b1, c, a);
		rd(OFS_SAMPLE, r);
		`CHK(r[15:0], x[47:32])
		rd(OFS_RESULT, r);
		`CHK(r, x[31:0])
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] r;
		rd(OFS_CONTROL_C, r);
		`CHK(r, 32'h00000100)
		rd(OFS_AMP_CTRL, r);
		`CHK(r[0], 1'b0)
		`CHK(route.amplifierEnable, 1'b0)
		wr(8'h2c, 32'hffffffff);
		rd(8'h2c, r);
		`CHK(r, 32'h00000000)
		`CHK(hresp, 1'b0)
		// Continuous conversion is set, then cleared before any input changes.
		wr(OFS_CONTROL_F, 32'h20);
		#1 `CHK(continuousConversion, 1'b1)
		wr(OFS_CONTROL_F, 32'h0);
		#1 `CHK(continuousConversion, 1'b0)
	endtask

	task automatic t_format();
		fmt_case(3'h0, 1'b0, 1'b1, 4'h0, 12'h3a5, 24'h0);
		fmt_case(3'h0, 1'b1, 1'b0, 4'h0, 12'h0f0, 24'h0);
		fmt_case(3'h1, 1'b0, 1'b0, 4'h0, 12'habc, 24'h0);
		fmt_case(3'h1, 1'b1, 1'b1, 4'h0, 12'h900, 24'h0);
		fmt_case(3'h2, 1'b1, 1'b1, 4'h0, 12'h123, 24'h800001);
		fmt_case(3'h3, 1'b0, 1'b0, 4'h6, 12'h456, 24'h012345);
		fmt_case(3'h5, 1'b0, 1'b1, 4'h2, 12'h789, 24'h000fff);
		fmt_case(3'h5, 1'b1, 1'b0, 4'h5, 12'h800, 24'hfff000);
		fmt_case(3'h4, 1'b0, 1'b1, 4'h0, 12'h7ff, 24'habcdef);
	endtask

	// Modes above five must leave the last legal mode in place.
	task automatic t_modes();
		logic [31:0] r;
		for (int i = 0; i < 8; i++) begin
			wr(OFS_COMMAND, i);
			rd(OFS_COMMAND, r);
			`CHK(r[2:0], (i > 5) ? 3'h5 : 3'(i))
		end
	endtask

	task automatic t_mux();
		logic [31:0] r;
		wr(OFS_POS_MUX, 32'h45);
		#1 `CHK(route.positiveInputSelect, 6'h05)
		rd(OFS_NEG_MUX, r);
		`CHK(r[7:6], 2'h1)
		wr(OFS_NEG_MUX, 32'h8a);
		rd(OFS_POS_MUX, r);
		`CHK(r[7:6], 2'h2)
		wr(OFS_COMMAND, 32'h1);
		#1 `CHK(route.negativeInputSelect, 6'h00)
		wr(OFS_COMMAND, 32'h11);
		#1 `CHK(route.negativeInputSelect, 6'h0a)
	endtask

	// Gains one to sixteen; a sixth code is refused.
	task automatic t_amp();
		for (int g = 0; g < 6; g++) begin
			wr(OFS_AMP_CTRL, 32'h201 | (g << 4));
			#1 `CHK(route.amplifierEnable, 1'b1)
			`CHK(route.amplifierGain, (g > 4) ? 3'h4 : 3'(g))
			`CHK(route.amplifierBiasSelect, 2'h2)
		end
		wr(OFS_AMP_CTRL, 32'h0);
		#1 `CHK(route.amplifierEnable, 1'b0)
	endtask

	task automatic t_clocks();
		int ticks, rises;
		logic prev;
		ticks = 0;
		rises = 0;
		wr(OFS_CONTROL_B, 32'h1);
		// One microsecond is 100 cycles of the 10 ns clock.
		wr(OFS_CONTROL_C, 32'h6405);
		#1 `CHK(route.referenceSelect, 3'h5)
		repeat (8) @(posedge clk);
		#1 prev = converterClock;
		repeat (300) begin
			@(posedge clk) #1;
			ticks += (microsecondTick === 1'b1);
			rises += (converterClock === 1'b1 && prev === 1'b0);
			prev = converterClock;
		end
		`CHK(ticks, 3)
		`CHK(rises, 75)
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		conversionDone = 1'b0;
		accumulationDone = 1'b0;
		conversionData = 12'h0;
		accumulationData = 24'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_format();
		t_modes();
		t_mux();
		t_amp();
		t_clocks();
		end_sim();
	end

	// The whole sequence needs well under a tenth of this span.
	initial begin
		#100000;
		errTotal++;
		end_sim();
	end
endmodule // arf_control_tb
